/* rtl/mba_consts.svh */
// constants for the bus arbiter front end
// Overview of operation
// [RL1] request, hold and release shared bus
// [RL2] outside logic picks cycles and priority
// [RL3] processor and bus state machines cooperate
// [RL4] request/priority signals suit chained resolution
// [RL5] processor machine steps on clock falling edge
// [RL6] shared input active from status or hold
// [RL7] high at reset release selects hold mode
// [RL8] low at reset release selects status mode
// [RL9] status low on falling edge starts cycle
// [RL10] select high after status requests bus
// [RL11] select resampled each falling edge
// [RL12] ready low ends cycle, high continues
// [RL13] reset puts both machines in idle
// [RL14] both status high means idle
`ifndef MBA_CONSTS_SVH
`define MBA_CONSTS_SVH
`define MBA_SYNC_DEPTH 2
`define MBA_MODE_STATUS 1'b0
`define MBA_MODE_HOLD   1'b1
`endif

/* rtl/mba_pkg.sv */
// types for the bus arbiter front end
package mba_pkg;
  typedef enum logic [1:0] {
    MBA_P_IDLE  = 2'b00,
    MBA_P_CYCLE = 2'b01,
    MBA_P_SYS   = 2'b10
  } mba_proc_state_t;
  typedef enum logic [1:0] {
    MBA_B_IDLE = 2'b00,
    MBA_B_REQ  = 2'b01,
    MBA_B_OWN  = 2'b10
  } mba_bus_state_t;
  typedef struct packed {
    logic status_or_hold_in;
    logic status_line_one;
    logic mem_io_select;
    logic system_or_resident_select;
    logic ready_n;
    logic sys_clk;
    logic bus_clk;
    logic bus_grant;
  } mba_pins_t;
endpackage : mba_pkg

/* rtl/mba_sync.sv */
// two-stage synchroniser for a pin group
`timescale 1ns/1ps
module mba_sync #(
  parameter int WIDTH = 8
) (
  // clock
  input  wire logic             clk,
  // pins
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  // no reset: the mode pin must be seen while reset is held
  always_ff @(posedge clk) begin
    meta_reg <= d;
    q        <= meta_reg;
  end
endmodule : mba_sync

/* rtl/mba_front.sv */
// processor-side and bus-side machines of the arbiter front end
`timescale 1ns/1ps
`include "mba_consts.svh"
module mba_front (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // processor, bus controller and bus side pins
  input  wire mba_pkg::mba_pins_t pins,
  // system bus side
  output logic              bus_request,
  output logic              bus_priority_out,
  output logic              bus_owned,
  // status
  output logic              cycle_active,
  output logic              hold_mode
);
  mba_pkg::mba_pins_t s;
  mba_pkg::mba_proc_state_t p_reg, p_next;
  mba_pkg::mba_bus_state_t  b_reg, b_next;
  mba_pkg::mba_bus_state_t  b_upd;
  logic sclk_d_reg, bclk_d_reg, rst_d_reg;
  logic mode_reg, mode_next;

  mba_sync #(.WIDTH($bits(mba_pkg::mba_pins_t))) u_sync (
    .clk (clk),
    .d   (pins),
    .q   (s)
  );

  // ==========================================================
  // edge and input decode
  wire sclk_fall = sclk_d_reg & ~s.sys_clk; // RL5
  wire bclk_fall = bclk_d_reg & ~s.bus_clk;
  wire rst_fall  = rst_d_reg & ~rst;
  assign mode_next = rst_fall ? s.status_or_hold_in : mode_reg; // RL7 RL8
  // shared input asserted by low status or high hold
  wire shared_act = mode_reg ? s.status_or_hold_in
                             : ~s.status_or_hold_in; // RL6
  wire line_one_act = ~s.status_line_one;
  // idle when both status lines high
  wire start = shared_act | line_one_act; // RL9 RL14
  wire sys_sel = s.system_or_resident_select;
  wire done = ~s.ready_n; // RL12
  wire want_bus = (p_reg != mba_pkg::MBA_P_IDLE) & sys_sel;

  // ==========================================================
  // processor-side machine
  always_comb begin
    p_next = p_reg;
    case (p_reg)
      mba_pkg::MBA_P_IDLE:
        if (start) begin
          p_next = mba_pkg::MBA_P_CYCLE; // RL9
        end
      mba_pkg::MBA_P_CYCLE:
        if (done) begin
          p_next = mba_pkg::MBA_P_IDLE; // RL12
        end else if (sys_sel) begin
          p_next = mba_pkg::MBA_P_SYS; // RL10
        end
      mba_pkg::MBA_P_SYS:
        if (done | ~sys_sel) begin
          p_next = mba_pkg::MBA_P_IDLE; // RL11
        end
      default: p_next = mba_pkg::MBA_P_IDLE;
    endcase
  end

  // ==========================================================
  // bus-side machine
  always_comb begin
    b_next = b_reg;
    case (b_reg)
      mba_pkg::MBA_B_IDLE:
        if (want_bus) begin
          b_next = mba_pkg::MBA_B_REQ; // RL1
        end
      mba_pkg::MBA_B_REQ:
        if (s.bus_grant) begin
          b_next = mba_pkg::MBA_B_OWN; // RL4
        end else if (!want_bus) begin
          b_next = mba_pkg::MBA_B_IDLE;
        end
      mba_pkg::MBA_B_OWN:
        if (!want_bus) begin
          b_next = mba_pkg::MBA_B_IDLE; // RL1
        end
      default: b_next = mba_pkg::MBA_B_IDLE;
    endcase
  end

  // bus state as it stands once this clock has passed
  assign b_upd = bclk_fall ? b_next : b_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      p_reg      <= mba_pkg::MBA_P_IDLE; // RL13
      b_reg      <= mba_pkg::MBA_B_IDLE; // RL13
      sclk_d_reg <= 1'b0;
      bclk_d_reg <= 1'b0;
      mode_reg   <= `MBA_MODE_STATUS;
    end else begin
      sclk_d_reg <= s.sys_clk;
      bclk_d_reg <= s.bus_clk;
      mode_reg   <= mode_next;
      if (sclk_fall) begin
        p_reg <= p_next; // RL3 RL5
      end
      if (bclk_fall) begin
        b_reg <= b_next; // RL3
      end
    end
  end

  always_ff @(posedge clk) begin
    rst_d_reg <= rst;
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_request      <= 1'b0;
      bus_priority_out <= 1'b0;
      bus_owned        <= 1'b0;
      cycle_active     <= 1'b0;
      hold_mode        <= `MBA_MODE_STATUS;
    end else begin
      bus_request      <= (b_upd != mba_pkg::MBA_B_IDLE); // RL1
      // pass priority down the chain while granted and the bus machine is idle
      bus_priority_out <= s.bus_grant & (b_reg == mba_pkg::MBA_B_IDLE); // RL4
      bus_owned        <= (b_upd == mba_pkg::MBA_B_OWN); // RL1
      cycle_active     <= (p_reg != mba_pkg::MBA_P_IDLE);
      hold_mode        <= mode_reg;
    end
  end

  // ==========================================================
  // reset and mode checks
  a_reset_idle: assert property (@(posedge clk) rst |=> !bus_request) // RL13
    else $error("request during reset");
  a_reset_quiet: assert property (@(posedge clk) // RL13
    rst |=> !bus_owned && !cycle_active && !hold_mode)
    else $error("outputs active during reset");
  a_mode_latch: assert property (@(posedge clk) // RL7
    rst_fall |=> mode_reg == $past(s.status_or_hold_in))
    else $error("mode not latched");
  a_mode_hold: assert property (@(posedge clk) disable iff (rst) // RL8
    !rst_fall |=> $stable(mode_reg))
    else $error("mode changed");
  a_hold_start: assert property (@(posedge clk) disable iff (rst) // RL6
    sclk_fall && p_reg == mba_pkg::MBA_P_IDLE && mode_reg
    && s.status_or_hold_in |=> p_reg == mba_pkg::MBA_P_CYCLE)
    else $error("hold request did not start cycle");

  // ==========================================================
  // processor machine checks
  a_step_fall: assert property (@(posedge clk) disable iff (rst) // RL5
    !sclk_fall |=> $stable(p_reg))
    else $error("processor machine moved off edge");
  a_idle_start: assert property (@(posedge clk) disable iff (rst) // RL14
    sclk_fall && p_reg == mba_pkg::MBA_P_IDLE && !start
    |=> p_reg == mba_pkg::MBA_P_IDLE)
    else $error("cycle started while idle");
  a_ready_ends: assert property (@(posedge clk) disable iff (rst) // RL12
    sclk_fall && p_reg != mba_pkg::MBA_P_IDLE && done
    |=> p_reg == mba_pkg::MBA_P_IDLE)
    else $error("ready did not end cycle");
  a_start_cycle: assert property (@(posedge clk) disable iff (rst) // RL9
    sclk_fall && p_reg == mba_pkg::MBA_P_IDLE && start
    |=> p_reg == mba_pkg::MBA_P_CYCLE)
    else $error("start missed");
  a_sys_req: assert property (@(posedge clk) disable iff (rst) // RL10
    sclk_fall && p_reg == mba_pkg::MBA_P_CYCLE && sys_sel && !done
    |=> p_reg == mba_pkg::MBA_P_SYS)
    else $error("system select ignored");
  a_sel_drop: assert property (@(posedge clk) disable iff (rst) // RL11
    sclk_fall && p_reg == mba_pkg::MBA_P_SYS && !sys_sel
    |=> p_reg == mba_pkg::MBA_P_IDLE)
    else $error("select drop ignored");
  a_sys_stays: assert property (@(posedge clk) disable iff (rst) // RL11
    sclk_fall && p_reg == mba_pkg::MBA_P_SYS && sys_sel && !done
    |=> p_reg == mba_pkg::MBA_P_SYS)
    else $error("system cycle left early");
  a_local_stays: assert property (@(posedge clk) disable iff (rst) // RL11
    sclk_fall && p_reg == mba_pkg::MBA_P_CYCLE && !sys_sel && !done
    |=> p_reg == mba_pkg::MBA_P_CYCLE)
    else $error("resident cycle left early");

  // ==========================================================
  // bus machine checks
  a_bus_step: assert property (@(posedge clk) disable iff (rst) // RL3
    !bclk_fall |=> $stable(b_reg))
    else $error("bus machine moved off edge");
  a_bus_request: assert property (@(posedge clk) disable iff (rst) // RL1
    bclk_fall && b_reg == mba_pkg::MBA_B_IDLE && want_bus
    |=> b_reg == mba_pkg::MBA_B_REQ)
    else $error("bus not requested");
  a_req_wait: assert property (@(posedge clk) disable iff (rst) // RL4
    bclk_fall && b_reg == mba_pkg::MBA_B_REQ && want_bus && !s.bus_grant
    |=> b_reg == mba_pkg::MBA_B_REQ)
    else $error("request dropped while waiting");
  a_grant_owns: assert property (@(posedge clk) disable iff (rst) // RL4
    bclk_fall && b_reg == mba_pkg::MBA_B_REQ && s.bus_grant
    |=> b_reg == mba_pkg::MBA_B_OWN)
    else $error("grant not taken");
  a_bus_release: assert property (@(posedge clk) disable iff (rst) // RL1
    bclk_fall && b_reg == mba_pkg::MBA_B_OWN && !want_bus
    |=> b_reg == mba_pkg::MBA_B_IDLE)
    else $error("bus not released");
  a_owned_req: assert property (@(posedge clk) disable iff (rst) // RL1
    bus_owned |-> bus_request)
    else $error("owned without request");
  a_prio_idle: assert property (@(posedge clk) disable iff (rst) // RL4
    bus_priority_out |-> !bus_owned)
    else $error("priority passed while owning");

  // ==========================================================
  // scenarios covered
  c_sys_cycle: cover property (@(posedge clk) p_reg == mba_pkg::MBA_P_SYS);
  c_bus_own: cover property (@(posedge clk) b_reg == mba_pkg::MBA_B_OWN);
  c_hold_mode: cover property (@(posedge clk) mode_reg);
  c_bus_wait: cover property (@(posedge clk)
    b_reg == mba_pkg::MBA_B_REQ && !s.bus_grant);
  c_prio_pass: cover property (@(posedge clk) bus_priority_out);
endmodule : mba_front

/* tb/mba_far.sv */
// far side model: processor clock, bus clock, priority resolver
`timescale 1ns/1ps
module mba_far #(
  parameter int LAG = 2
) (
  // control
  input  wire logic run,
  input  wire logic bus_request,
  // clocks and grant
  output logic      sys_clk,
  output logic      bus_clk,
  output logic      bus_grant
);
  int wait_cnt;
  initial begin
    sys_clk = 1'b1;
    forever #40 sys_clk = run ? ~sys_clk : 1'b1;
  end
  initial begin
    bus_clk = 1'b1;
    #13;
    forever #80 bus_clk = run ? ~bus_clk : 1'b1;
  end
  initial begin
    bus_grant = 1'b0;
    wait_cnt = 0;
  end
  // grant after LAG bus clocks of request, dropped with it
  always @(posedge bus_clk) begin
    wait_cnt <= bus_request ? wait_cnt + 1 : 0;
    bus_grant <= bus_request && wait_cnt >= LAG;
  end
endmodule : mba_far

/* tb/tb.sv */
// self-checking bench for the arbiter front end
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic s0; logic s1; logic sel; logic cyc; logic req;
  } mba_row_t;
  logic clk, rst, s0, s1, sel, rdy_n, run;
  logic sck, bck, gnt, breq, bpro, bown, cyc, hmode;
  int bad_count, check_count;
  mba_pkg::mba_pins_t pins;
  mba_row_t rows [4];
  assign pins = {s0, s1, 1'b1, sel, rdy_n, sck, bck, gnt};
  mba_front dut_u (.clk(clk), .rst(rst), .pins(pins), .bus_request(breq),
    .bus_priority_out(bpro), .bus_owned(bown), .cycle_active(cyc),
    .hold_mode(hmode));
  mba_far far_u (.run(run), .bus_request(breq), .sys_clk(sck),
    .bus_clk(bck), .bus_grant(gnt));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================
  // helpers
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %b", $time, what, got);
    end
  endtask : chk
  function automatic logic pick(input int k);
    return (k == 0) ? cyc : (k == 1) ? breq : bown;
  endfunction : pick
  // bounded wait for a level on cyc, breq or bown
  task automatic await(input int k, input logic lvl);
    int i;
    for (i = 0; i < 400 && pick(k) !== lvl; i++) @(negedge clk);
    if (i == 400) begin
      bad_count++;
      $display("ERROR %0t wait ran out", $time);
      report_and_stop();
    end
  endtask : await
  // ==========================================
  // main sequence
  initial begin
    rows[0] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    rows[1] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    rows[2] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    rows[3] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    {rst, s0, s1, sel, rdy_n, run} = 6'b101110;
    bad_count = 0;
    check_count = 0;
    repeat (5) @(negedge clk);
    chk(breq | bown | cyc, 1'b0, "idle in reset");
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk(hmode, 1'b0, "status mode");
    $display("reset test done");
    s0 = 1'b1;
    repeat (4) @(negedge clk);
    run = 1'b1;
    foreach (rows[r]) begin
      {s0, s1, sel} = {rows[r].s0, rows[r].s1, rows[r].sel};
      if (rows[r].cyc) await(0, 1'b1);
      else repeat (60) @(negedge clk);
      chk(cyc, rows[r].cyc, "cycle start");
      {s0, s1} = 2'b11;
      if (rows[r].req) begin
        await(1, 1'b1);
        await(2, 1'b1);
        chk(bown, 1'b1, "bus owned");
        chk(bpro, 1'b0, "priority kept while owned");
        chk(cyc, 1'b1, "held while not ready");
      end else begin
        repeat (60) @(negedge clk);
      end
      chk(breq, rows[r].req, "system select");
      rdy_n = 1'b0;
      await(0, 1'b0);
      await(1, 1'b0);
      chk(bown, 1'b0, "bus released");
      rdy_n = 1'b1;
      @(negedge clk);
      chk(bpro, rows[r].req, "priority passed on");
      $display("row %0d done", r);
    end
    rst = 1'b1;
    run = 1'b0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk(hmode, 1'b1, "hold mode");
    s0 = 1'b0;
    run = 1'b1;
    repeat (20) @(negedge clk);
    chk(cyc, 1'b0, "hold idle");
    s0 = 1'b1;
    await(1, 1'b1);
    chk(cyc, 1'b1, "hold starts cycle");
    rst = 1'b1;
    @(negedge clk);
    @(negedge clk);
    chk(breq | cyc | bown, 1'b0, "reset mid cycle");
    $display("hold and reset test done");
    report_and_stop();
  end
endmodule : tb
